// *** core/tlx_regs.sv ***
`timescale 1ns/100ps
`include "tlx_consts.svh"

// Operation
// - Capability register readable, writes alter link
// - Reset restores capability register default
// - Interface type latched in init after reset, then fixed
// - Respond old speed, switch, then ready
// - Current capability storable as reset default
// - Three capability views kept non-volatile
// - Capability errors: fault status, zero data
// - Two window sets; first preloaded automatically
// - Second set untouched by first set use
// - Window write error: zero data, address kept
// - Configuration fields: steps, space, step size
// - Six high bits plus low form 22 bits
// - Data window reads/writes selected location
// - No address step after execution error
module tlx_regs
  import tlx_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Command from packet decoder
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_reg,
  input  wire logic [15:0] cmd_data,
  output logic             cmd_ready,
  // Response to packet encoder
  output logic             rsp_valid,
  output logic             rsp_ok,
  output tlx_err_t         rsp_err,
  output logic [15:0]      rsp_data,
  input  wire logic        rsp_done,
  // Automatic window preload
  input  wire logic        aea_load,
  input  wire logic [15:0] aea_cfg,
  input  wire logic [15:0] aea_addr,
  // Module context
  input  wire logic        traffic_on,
  input  wire logic        store_default,
  input  wire logic [1:0]  if_type_pin,
  // Link control
  output logic [3:0]       link_speed,
  output logic [1:0]       link_type,
  output logic             link_ready_n
);

  tlx_regs_t r_q;
  tlx_regs_t r_d;
  tlx_mem_if mbus ();

  tlx_mem u_mem
  (
    .clk (clk),
    .m   (mbus)
  );

  // ============================================================
  // Window helpers
  // Map a set onto the store; only spaces 1 to 4 are backed
  function automatic logic [9:0] win_loc(input logic [15:0] cfg, input logic [15:0] low);
    tlx_win_cfg_t c;
    logic [21:0]  a;
    logic [2:0]   s;
    c = tlx_win_cfg_t'(cfg);
    a = {c.addr_high, low};
    s = c.space_select - `TLX_SPACE_FIRST;
    win_loc = {(c.space_select >= `TLX_SPACE_FIRST) && (c.space_select <= `TLX_SPACE_LAST) &&
               (a < `TLX_WIN_WORDS), 1'b0, s[1:0], a[5:0]};
  endfunction

  // Post step of the 22-bit address; wraps at the ends
  function automatic logic [21:0] win_step(input logic [15:0] cfg, input logic [15:0] low,
                                           input logic [1:0] dir);
    tlx_win_cfg_t c;
    logic [21:0]  a;
    c = tlx_win_cfg_t'(cfg);
    a = {c.addr_high, low};
    win_step = a;
    if (dir == `TLX_STEP_INC)
    begin
      win_step = a + {20'h00000, c.step_size};
    end
    else if (dir == `TLX_STEP_DEC)
    begin
      win_step = a - {20'h00000, c.step_size};
    end
  endfunction

  // ============================================================
  // Next state
  always_comb
  begin
    logic [9:0]   loc;
    logic [21:0]  na;
    logic [15:0]  cfg;
    logic [15:0]  low;
    tlx_win_cfg_t wc;
    loc = 10'h000;
    na = 22'h000000;
    cfg = 16'h0000;
    low = 16'h0000;
    wc = tlx_win_cfg_t'(16'h0000);
    r_d = r_q;
    r_d.rsp_valid = 1'b0;
    r_d.mem_en = 1'b0;
    r_d.mem_we = 1'b0;
    // Two-flop synchroniser for the interface type strap
    r_d.strap_s1 = if_type_pin;
    r_d.strap_s2 = r_q.strap_s1;
    case (r_q.state)
      TLX_INIT:
      begin
        // Let the strap settle, then latch it for good
        if (r_q.init_cnt == `TLX_INIT_WAIT)
        begin
          r_d.if_type = (r_q.strap_s2 > `TLX_VIEW_LAST) ? 2'h0 : r_q.strap_s2;
          r_d.mem_en = 1'b1;
          r_d.mem_addr = `TLX_VIEW_BASE + {7'h00, r_d.if_type};
          r_d.state = TLX_INIT_RD;
        end
        else
        begin
          r_d.init_cnt = r_q.init_cnt + 2'h1;
        end
      end
      TLX_INIT_RD:
      begin
        r_d.state = TLX_INIT_LD;
      end
      TLX_INIT_LD:
      begin
        // Saved default comes back after every reset
        r_d.iocap = mbus.rdata;
        r_d.iocap[`TLX_IOCAP_TYPE_MSB:`TLX_IOCAP_TYPE_LSB] = r_q.if_type;
        r_d.link_speed = mbus.rdata[`TLX_IOCAP_SPD_MSB:`TLX_IOCAP_SPD_LSB];
        r_d.ready_n = 1'b0;
        r_d.state = TLX_IDLE;
      end
      TLX_IDLE:
      begin
        if (cmd_valid && r_q.cmd_ready)
        begin
          r_d.rsp_valid = 1'b1;
          r_d.rsp_ok = 1'b1;
          r_d.rsp_err = TLX_ERR_OK;
          r_d.rsp_data = cmd_write ? cmd_data : 16'h0000;
          if (cmd_reg == `TLX_REG_IOCAP)
          begin
            if (!cmd_write)
            begin
              r_d.rsp_data = r_q.iocap;
            end
            else if (traffic_on)
            begin
              r_d.rsp_err = TLX_ERR_CMD_IGNORED_BUSY;
            end
            else if (cmd_data[`TLX_IOCAP_TYPE_MSB:`TLX_IOCAP_TYPE_LSB] != r_q.if_type)
            begin
              r_d.rsp_err = TLX_ERR_RANGE_VALUE;
            end
            else if (cmd_data[`TLX_IOCAP_SPD_MSB:`TLX_IOCAP_SPD_LSB] > `TLX_SPEED_MAX)
            begin
              r_d.rsp_err = TLX_ERR_RANGE_VALUE;
            end
            else
            begin
              r_d.iocap = cmd_data;
              r_d.new_speed = cmd_data[`TLX_IOCAP_SPD_MSB:`TLX_IOCAP_SPD_LSB];
              if (r_d.new_speed != r_q.link_speed)
              begin
                r_d.state = TLX_SPD_WAIT;
              end
            end
          end
          else if ((cmd_reg == `TLX_REG_AW_CFG) || (cmd_reg == `TLX_REG_W_CFG))
          begin
            wc = tlx_win_cfg_t'(cmd_data);
            if (!cmd_write)
            begin
              r_d.rsp_data = (cmd_reg == `TLX_REG_AW_CFG) ? r_q.aw_cfg : r_q.w_cfg;
            end
            else if ((wc.read_step_dir == `TLX_STEP_UNDEF) || (wc.write_step_dir == `TLX_STEP_UNDEF))
            begin
              r_d.rsp_err = TLX_ERR_RANGE_VALUE;
            end
            else if (cmd_reg == `TLX_REG_AW_CFG)
            begin
              r_d.aw_cfg = cmd_data & ~`TLX_CFG_RSVD_MASK;
            end
            else
            begin
              r_d.w_cfg = cmd_data & ~`TLX_CFG_RSVD_MASK;
            end
          end
          else if ((cmd_reg == `TLX_REG_AW_LOW) || (cmd_reg == `TLX_REG_W_LOW))
          begin
            if (!cmd_write)
            begin
              r_d.rsp_data = (cmd_reg == `TLX_REG_AW_LOW) ? r_q.aw_low : r_q.w_low;
            end
            else if (cmd_reg == `TLX_REG_AW_LOW)
            begin
              r_d.aw_low = cmd_data;
            end
            else
            begin
              r_d.w_low = cmd_data;
            end
          end
          else if ((cmd_reg == `TLX_REG_AW_DATA) || (cmd_reg == `TLX_REG_W_DATA))
          begin
            // Each data window works only on its own set
            r_d.pend_set = (cmd_reg == `TLX_REG_W_DATA);
            cfg = r_d.pend_set ? r_q.w_cfg : r_q.aw_cfg;
            low = r_d.pend_set ? r_q.w_low : r_q.aw_low;
            wc = tlx_win_cfg_t'(cfg);
            loc = win_loc(cfg, low);
            if (!loc[9])
            begin
              r_d.rsp_err = cmd_write ? TLX_ERR_EXT_RANGE_OVERFLOW : TLX_ERR_EXT_READ;
            end
            else if (!cmd_write)
            begin
              r_d.rsp_valid = 1'b0;
              r_d.mem_en = 1'b1;
              r_d.mem_addr = loc[8:0];
              r_d.state = TLX_MEM_WAIT;
            end
            else
            begin
              r_d.mem_en = 1'b1;
              r_d.mem_we = 1'b1;
              r_d.mem_addr = loc[8:0];
              r_d.mem_wdata = cmd_data;
              na = win_step(cfg, low, wc.write_step_dir);
              if (r_d.pend_set)
              begin
                r_d.w_cfg[5:0] = na[21:16];
                r_d.w_low = na[15:0];
              end
              else
              begin
                r_d.aw_cfg[5:0] = na[21:16];
                r_d.aw_low = na[15:0];
              end
            end
          end
          else
          begin
            r_d.rsp_err = TLX_ERR_EXEC_FAULT;
          end
          // Any failure answers fault status with zero data, nothing stepped
          if (r_d.rsp_err != TLX_ERR_OK)
          begin
            r_d.rsp_ok = 1'b0;
            r_d.rsp_data = `TLX_ERR_DATA;
          end
        end
        else if (r_q.store_pend)
        begin
          // Save the live capability into the view of the strapped type
          r_d.store_pend = 1'b0;
          r_d.mem_en = 1'b1;
          r_d.mem_we = 1'b1;
          r_d.mem_addr = `TLX_VIEW_BASE + {7'h00, r_q.if_type};
          r_d.mem_wdata = r_q.iocap;
        end
      end
      TLX_MEM_WAIT:
      begin
        r_d.state = TLX_MEM_DONE;
      end
      TLX_MEM_DONE:
      begin
        // Read data is back; step only now that the read succeeded
        cfg = r_q.pend_set ? r_q.w_cfg : r_q.aw_cfg;
        low = r_q.pend_set ? r_q.w_low : r_q.aw_low;
        wc = tlx_win_cfg_t'(cfg);
        na = win_step(cfg, low, wc.read_step_dir);
        if (r_q.pend_set)
        begin
          r_d.w_cfg[5:0] = na[21:16];
          r_d.w_low = na[15:0];
        end
        else
        begin
          r_d.aw_cfg[5:0] = na[21:16];
          r_d.aw_low = na[15:0];
        end
        r_d.rsp_valid = 1'b1;
        r_d.rsp_ok = 1'b1;
        r_d.rsp_err = TLX_ERR_OK;
        r_d.rsp_data = mbus.rdata;
        r_d.state = TLX_IDLE;
      end
      TLX_SPD_WAIT:
      begin
        // Old speed stays until the answer has left the module
        if (rsp_done)
        begin
          r_d.link_speed = r_q.new_speed;
          r_d.ready_n = 1'b1;
          r_d.settle_cnt = 8'(`TLX_SETTLE_CYC - 1);
          r_d.state = TLX_SPD_SETTLE;
        end
      end
      TLX_SPD_SETTLE:
      begin
        if (r_q.settle_cnt == 8'h00)
        begin
          r_d.ready_n = 1'b0;
          r_d.state = TLX_IDLE;
        end
        else
        begin
          r_d.settle_cnt = r_q.settle_cnt - 8'h01;
        end
      end
      default:
      begin
        r_d.state = TLX_INIT;
      end
    endcase
    // Save request is held until the store port is free; a new request beats the clear
    if (store_default)
    begin
      r_d.store_pend = 1'b1;
    end
    // Preload of the first set takes priority over a host write to it
    if (aea_load)
    begin
      r_d.aw_cfg = aea_cfg & ~`TLX_CFG_RSVD_MASK;
      r_d.aw_low = aea_addr;
    end
    // Commands during init are answered with an init error; speed change and reads stall
    r_d.cmd_ready = (r_d.state == TLX_IDLE);
    if ((r_q.state == TLX_INIT) && cmd_valid && !r_q.rsp_valid)
    begin
      r_d.rsp_valid = 1'b1;
      r_d.rsp_ok = 1'b0;
      r_d.rsp_err = TLX_ERR_CMD_IGNORED_INIT;
      r_d.rsp_data = `TLX_ERR_DATA;
    end
  end

  // ============================================================
  // State register; link is not ready until init loads the default
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      r_q <= '0;
      r_q.ready_n <= 1'b1;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // ============================================================
  // Outputs straight from the state register
  assign mbus.en      = r_q.mem_en;
  assign mbus.we      = r_q.mem_we;
  assign mbus.addr    = r_q.mem_addr;
  assign mbus.wdata   = r_q.mem_wdata;
  assign cmd_ready    = r_q.cmd_ready;
  assign rsp_valid    = r_q.rsp_valid;
  assign rsp_ok       = r_q.rsp_ok;
  assign rsp_err      = r_q.rsp_err;
  assign rsp_data     = r_q.rsp_data;
  assign link_speed   = r_q.link_speed;
  assign link_type    = r_q.if_type;
  assign link_ready_n = r_q.ready_n;

endmodule

// *** core/tlx_consts.svh ***
`ifndef TLX_CONSTS_SVH
`define TLX_CONSTS_SVH

// ============================================================
// Command register numbers
`define TLX_REG_AW_CFG      8'h09
`define TLX_REG_AW_LOW      8'h0a
`define TLX_REG_AW_DATA     8'h0b
`define TLX_REG_IOCAP       8'h0d
`define TLX_REG_W_CFG       8'h0e
`define TLX_REG_W_LOW       8'h0f
`define TLX_REG_W_DATA      8'h10

// ============================================================
// Reset values and fixed data
`define TLX_CFG_RST         16'h0000
`define TLX_LOW_RST         16'h0000
`define TLX_ERR_DATA        16'h0000
`define TLX_CFG_RSVD_MASK   16'h0040
`define TLX_IOCAP_DEFAULT   16'h0001

// ============================================================
// Window configuration field values
`define TLX_STEP_NONE       2'h0
`define TLX_STEP_INC        2'h1
`define TLX_STEP_DEC        2'h2
`define TLX_STEP_UNDEF      2'h3
`define TLX_SPACE_FIRST     3'h1
`define TLX_SPACE_LAST      3'h4

// ============================================================
// Interface capability field layout
`define TLX_IOCAP_TYPE_MSB  15
`define TLX_IOCAP_TYPE_LSB  14
`define TLX_IOCAP_SPD_MSB   3
`define TLX_IOCAP_SPD_LSB   0
`define TLX_SPEED_MAX       4'h7
`define TLX_VIEW_LAST       2'h2

// ============================================================
// Location store layout
`define TLX_MEM_AW          9
`define TLX_MEM_DEPTH       512
`define TLX_WIN_WORDS       22'h000040
`define TLX_VIEW_BASE       9'h100

// ============================================================
// Timing
`define TLX_CLK_PERIOD_NS   25
`define TLX_SETTLE_NS       1000
`define TLX_SETTLE_CYC      ((`TLX_SETTLE_NS + `TLX_CLK_PERIOD_NS - 1) / `TLX_CLK_PERIOD_NS)
`define TLX_INIT_WAIT       2'h3

`endif

// *** core/tlx_pkg.sv ***
package tlx_pkg;

  // ============================================================
  // Controller states
  typedef enum logic [2:0] {
    TLX_INIT,
    TLX_INIT_RD,
    TLX_INIT_LD,
    TLX_IDLE,
    TLX_MEM_WAIT,
    TLX_MEM_DONE,
    TLX_SPD_WAIT,
    TLX_SPD_SETTLE
  } tlx_state_t;

  // Error condition codes returned beside the status
  typedef enum logic [3:0] {
    TLX_ERR_OK,
    TLX_ERR_CMD_IN_PROGRESS,
    TLX_ERR_CMD_IGNORED_INIT,
    TLX_ERR_EXEC_FAULT,
    TLX_ERR_VENDOR_SPECIFIC,
    TLX_ERR_READ_ONLY,
    TLX_ERR_RANGE_VALUE,
    TLX_ERR_CMD_IGNORED_BUSY,
    TLX_ERR_EXT_READ,
    TLX_ERR_EXT_RANGE_OVERFLOW
  } tlx_err_t;

  // Window configuration word
  typedef struct packed {
    logic [1:0] read_step_dir;
    logic [1:0] write_step_dir;
    logic [2:0] space_select;
    logic [1:0] step_size;
    logic       rsvd;
    logic [5:0] addr_high;
  } tlx_win_cfg_t;

  // Whole state of the register block
  typedef struct packed {
    tlx_state_t  state;
    logic [1:0]  init_cnt;
    logic [1:0]  strap_s1;
    logic [1:0]  strap_s2;
    logic [1:0]  if_type;
    logic [15:0] iocap;
    logic [3:0]  link_speed;
    logic [3:0]  new_speed;
    logic        ready_n;
    logic [7:0]  settle_cnt;
    logic [15:0] aw_cfg;
    logic [15:0] aw_low;
    logic [15:0] w_cfg;
    logic [15:0] w_low;
    logic        pend_set;
    logic        store_pend;
    logic        cmd_ready;
    logic        rsp_valid;
    logic        rsp_ok;
    tlx_err_t    rsp_err;
    logic [15:0] rsp_data;
    logic        mem_en;
    logic        mem_we;
    logic [8:0]  mem_addr;
    logic [15:0] mem_wdata;
  } tlx_regs_t;

endpackage

// *** core/tlx_mem_if.sv ***
`timescale 1ns/100ps

interface tlx_mem_if;
  logic        en;
  logic        we;
  logic [8:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;

  modport ctrl (output en, output we, output addr, output wdata, input rdata);
  modport mem  (input en, input we, input addr, input wdata, output rdata);
endinterface

// *** core/tlx_mem.sv ***
`timescale 1ns/100ps
`include "tlx_consts.svh"

// ============================================================
// Location store: window spaces plus the saved capability views
module tlx_mem
  import tlx_pkg::*;
(
  // Clock
  input  wire logic clk,
  // Access port
  tlx_mem_if.mem    m
);

  logic [15:0] store [`TLX_MEM_DEPTH];
  logic [15:0] rdata_q;

  // Contents survive reset; they take their starting values only at configuration time
  initial
  begin
    for (int i = 0; i < `TLX_MEM_DEPTH; i++)
    begin
      store[i] = (i >= `TLX_VIEW_BASE) ? `TLX_IOCAP_DEFAULT : 16'h0000;
    end
  end

  // One-cycle registered read, write-first is not needed; a plain always so the
  // power-on contents above and the write port may share the array
  always @(posedge clk)
  begin
    if (m.en)
    begin
      if (m.we)
      begin
        store[m.addr] <= m.wdata;
      end
      rdata_q <= store[m.addr];
    end
  end

  assign m.rdata = rdata_q;

endmodule

// *** test/tlx_enc_model.sv ***
`timescale 1ns/100ps

// ============================================================
// Packet encoder model: flags each answer as sent some cycles later
module tlx_enc_model #(
  parameter int DLY = 6
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Answer in, sent flag out
  input  wire logic rsp_valid,
  output logic      rsp_done
);
  int cnt;

  // Sending takes a while, so the block must hold the old speed meanwhile
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      cnt      <= 0;
      rsp_done <= 1'b0;
    end
    else
    begin
      rsp_done <= (cnt == 1);
      if (rsp_valid)
        cnt <= DLY;
      else if (cnt != 0)
        cnt <= cnt - 1;
    end
endmodule

// *** test/tlx_regs_sva.sv ***
`timescale 1ns/100ps

// ============================================================
// Port checker for the register block
module tlx_regs_sva
  import tlx_pkg::*;
(
  // Clock, reset, command
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cmd_valid,
  input wire logic        cmd_write,
  input wire logic [7:0]  cmd_reg,
  input wire logic [15:0] cmd_data,
  input wire logic        cmd_ready,
  // Answer
  input wire logic        rsp_valid,
  input wire logic        rsp_ok,
  input wire tlx_err_t    rsp_err,
  input wire logic [15:0] rsp_data,
  input wire logic        rsp_done,
  // Link
  input wire logic [3:0]  link_speed,
  input wire logic [1:0]  link_type,
  input wire logic        link_ready_n,
  input wire logic        traffic_on
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Accepted command
  sequence s_take;
    cmd_valid && cmd_ready;
  endsequence
  sequence s_win_rd;
    s_take ##0 (!cmd_write && (cmd_reg == 8'h0b || cmd_reg == 8'h10));
  endsequence
  sequence s_cap_wr;
    s_take ##0 (cmd_write && cmd_reg == 8'h0d);
  endsequence

  a_err_zero_data: assert property (rsp_valid && !rsp_ok |-> rsp_data == 16'h0000)
    else $error("error answer with nonzero data");
  a_ok_clean_code: assert property (rsp_valid && rsp_ok |-> rsp_err == TLX_ERR_OK)
    else $error("ok answer with error code");
  a_win_read_late: assert property (s_win_rd |=> (rsp_valid && !rsp_ok) or (!cmd_ready ##2 (rsp_valid && rsp_ok)))
    else $error("window read answer timing wrong");
  a_settle_exact: assert property ($rose(link_ready_n) |-> ##39 link_ready_n ##1 !link_ready_n)
    else $error("ready high time not 40 cycles");
  a_speed_after_sent: assert property ($changed(link_speed) && !$past(link_ready_n) |-> link_ready_n && $past(rsp_done))
    else $error("speed changed before packet sent");
  a_type_fixed: assert property (!$past(link_ready_n) |-> $stable(link_type))
    else $error("interface type changed in operation");
  a_ready_gates_cmd: assert property (cmd_ready |-> !link_ready_n)
    else $error("commands taken while link not ready");
  a_busy_refuse: assert property (s_cap_wr ##0 traffic_on |=> rsp_valid && !rsp_ok && rsp_err == TLX_ERR_CMD_IGNORED_BUSY)
    else $error("capability write with traffic not refused");
  a_bad_reg_fault: assert property (s_take ##0 cmd_reg == 8'h0c |=> rsp_valid && rsp_err == TLX_ERR_EXEC_FAULT)
    else $error("unknown register not faulted");
  a_cap_echo: assert property (s_cap_wr ##1 (rsp_valid && rsp_ok) |-> rsp_data == $past(cmd_data))
    else $error("capability write not echoed");
endmodule

bind tlx_regs tlx_regs_sva u_sva (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
  .cmd_reg(cmd_reg), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok),
  .rsp_err(rsp_err), .rsp_data(rsp_data), .rsp_done(rsp_done), .link_speed(link_speed),
  .link_type(link_type), .link_ready_n(link_ready_n), .traffic_on(traffic_on));

// *** test/io_cap_and_extended_address_regs_tb_top.sv ***
`timescale 1ns/100ps
`include "tlx_consts.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

// ============================================================
// Bench for the register block
module io_cap_and_extended_address_regs_tb_top
  import tlx_pkg::*;
;
  typedef struct packed {logic w; logic [7:0] r; logic [15:0] d; logic ok; tlx_err_t e; logic [15:0] q;} tlx_row_t;
  logic        clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, cmd_write = 1'b0, aea_load = 1'b0;
  logic        traffic_on = 1'b0, store_default = 1'b0;
  logic [7:0]  cmd_reg = 8'h00;
  logic [15:0] cmd_data = 16'h0000, aea_cfg = 16'h0000, aea_addr = 16'h0000, rsp_data;
  logic [1:0]  if_type_pin = 2'h0, link_type;
  logic [3:0]  link_speed;
  logic        cmd_ready, rsp_valid, rsp_ok, rsp_done, link_ready_n;
  tlx_err_t    rsp_err;
  int          n_errors = 0, checks_done = 0;
  // Ordinary cases: inputs, then expected status, code and data
  tlx_row_t rows [29] = '{
    '{0, 8'h09, 16'h0000, 1, TLX_ERR_OK, 16'h0000}, '{0, 8'h0e, 16'h0000, 1, TLX_ERR_OK, 16'h0000},
    '{0, 8'h0d, 16'h0000, 1, TLX_ERR_OK, 16'h0001}, '{1, 8'h0e, 16'h5280, 1, TLX_ERR_OK, 16'h5280},
    '{0, 8'h0e, 16'h0000, 1, TLX_ERR_OK, 16'h5280}, '{1, 8'h0f, 16'h0010, 1, TLX_ERR_OK, 16'h0010},
    '{1, 8'h10, 16'hbeef, 1, TLX_ERR_OK, 16'hbeef}, '{0, 8'h0f, 16'h0000, 1, TLX_ERR_OK, 16'h0011},
    '{1, 8'h0f, 16'h0010, 1, TLX_ERR_OK, 16'h0010}, '{0, 8'h10, 16'h0000, 1, TLX_ERR_OK, 16'hbeef},
    '{0, 8'h0f, 16'h0000, 1, TLX_ERR_OK, 16'h0011}, '{1, 8'h0e, 16'hc000, 0, TLX_ERR_RANGE_VALUE, 16'h0000},
    '{0, 8'h0e, 16'h0000, 1, TLX_ERR_OK, 16'h5280}, '{1, 8'h0f, 16'h0040, 1, TLX_ERR_OK, 16'h0040},
    '{1, 8'h10, 16'h1111, 0, TLX_ERR_EXT_RANGE_OVERFLOW, 16'h0000},
    '{0, 8'h10, 16'h0000, 0, TLX_ERR_EXT_READ, 16'h0000}, '{0, 8'h0f, 16'h0000, 1, TLX_ERR_OK, 16'h0040},
    '{1, 8'h09, 16'h5280, 1, TLX_ERR_OK, 16'h5280}, '{1, 8'h0a, 16'h0020, 1, TLX_ERR_OK, 16'h0020},
    '{1, 8'h0b, 16'h1234, 1, TLX_ERR_OK, 16'h1234}, '{0, 8'h0f, 16'h0000, 1, TLX_ERR_OK, 16'h0040},
    '{1, 8'h0d, 16'h4001, 0, TLX_ERR_RANGE_VALUE, 16'h0000},
    '{1, 8'h0d, 16'h0008, 0, TLX_ERR_RANGE_VALUE, 16'h0000},
    '{0, 8'h0c, 16'h0000, 0, TLX_ERR_EXEC_FAULT, 16'h0000}, '{1, 8'h0e, 16'h8900, 1, TLX_ERR_OK, 16'h8900},
    '{1, 8'h0f, 16'h0005, 1, TLX_ERR_OK, 16'h0005}, '{1, 8'h10, 16'haaaa, 1, TLX_ERR_OK, 16'haaaa},
    '{0, 8'h10, 16'h0000, 1, TLX_ERR_OK, 16'haaaa}, '{0, 8'h0f, 16'h0000, 1, TLX_ERR_OK, 16'h0003}};

  tlx_regs DUT (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_reg(cmd_reg),
    .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok), .rsp_err(rsp_err),
    .rsp_data(rsp_data), .rsp_done(rsp_done), .aea_load(aea_load), .aea_cfg(aea_cfg), .aea_addr(aea_addr),
    .traffic_on(traffic_on), .store_default(store_default), .if_type_pin(if_type_pin),
    .link_speed(link_speed), .link_type(link_type), .link_ready_n(link_ready_n));
  tlx_enc_model u_enc (.clk(clk), .rst(rst), .rsp_valid(rsp_valid), .rsp_done(rsp_done));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // ============================================================
  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // One command, held until taken, then wait for its answer; a stall ends the run
  task automatic cmd(input logic w, input logic [7:0] r, input logic [15:0] d);
    int i;
    cmd_write = w;
    cmd_reg   = r;
    cmd_data  = d;
    cmd_valid = 1'b1;
    i = 0;
    while (cmd_ready !== 1'b1 && i < 300)
    begin
      @(negedge clk);
      i++;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && i < 300)
    begin
      @(negedge clk);
      i++;
    end
    if (i >= 300)
    begin
      n_errors++;
      conclude();
    end
    @(negedge clk);
  endtask

  // Wait while the ready line sits at lvl, counting cycles
  task automatic hold_count(input logic lvl, output int n);
    n = 0;
    while (link_ready_n === lvl && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 300)
    begin
      n_errors++;
      conclude();
    end
  endtask

  // ============================================================
  // Main sequence
  initial
  begin
    int n;
    repeat (12) @(negedge clk);
    `CHK(link_ready_n, 1'b1)
    `CHK(cmd_ready, 1'b0)
    rst = 1'b0;
    foreach (rows[k])
    begin
      cmd(rows[k].w, rows[k].r, rows[k].d);
      `CHK(rsp_ok, rows[k].ok)
      `CHK(rsp_err, rows[k].e)
      `CHK(rsp_data, rows[k].q)
    end
    // Strap moves in operation: type must stay latched
    if_type_pin = 2'h2;
    repeat (4) @(negedge clk);
    `CHK(link_type, 2'h0)
    // Capability write refused while carrying traffic
    traffic_on = 1'b1;
    cmd(1'b1, `TLX_REG_IOCAP, 16'h0001);
    `CHK(rsp_err, TLX_ERR_CMD_IGNORED_BUSY)
    traffic_on = 1'b0;
    // Speed change: answer at old speed, switch, settle, ready
    cmd(1'b1, `TLX_REG_IOCAP, 16'h0003);
    `CHK(rsp_data, 16'h0003)
    `CHK(link_speed, 4'h1)
    hold_count(1'b0, n);
    hold_count(1'b1, n);
    `CHK(n, 40)
    `CHK(link_speed, 4'h3)
    // Preload of the first set leaves the second set alone
    aea_cfg  = 16'h52c1;
    aea_addr = 16'h0123;
    aea_load = 1'b1;
    @(negedge clk);
    aea_load = 1'b0;
    cmd(1'b0, `TLX_REG_AW_CFG, 16'h0000);
    `CHK(rsp_data, 16'h5281)
    cmd(1'b0, `TLX_REG_AW_LOW, 16'h0000);
    `CHK(rsp_data, 16'h0123)
    cmd(1'b0, `TLX_REG_W_LOW, 16'h0000);
    `CHK(rsp_data, 16'h0003)
    // Store the capability as default, then reset
    if_type_pin   = 2'h0;
    store_default = 1'b1;
    @(negedge clk);
    store_default = 1'b0;
    repeat (20) @(negedge clk);
    rst = 1'b1;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    cmd(1'b0, `TLX_REG_IOCAP, 16'h0000);
    `CHK(rsp_data, 16'h0003)
    `CHK(link_speed, 4'h3)
    cmd(1'b0, `TLX_REG_W_CFG, 16'h0000);
    `CHK(rsp_data, 16'h0000)
    // Strap is latched in init after reset; a command in init is refused
    if_type_pin = 2'h1;
    rst = 1'b1;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    cmd_write = 1'b0;
    cmd_reg   = `TLX_REG_IOCAP;
    cmd_valid = 1'b1;
    @(negedge clk);
    `CHK(rsp_valid, 1'b1)
    `CHK(rsp_err, TLX_ERR_CMD_IGNORED_INIT)
    cmd(1'b0, `TLX_REG_IOCAP, 16'h0000);
    `CHK(link_type, 2'h1)
    `CHK(rsp_data, 16'h4001)
    conclude();
  end
endmodule
